// *** hw/imsp_port.sv ***
// two-wire bus port: master and slave engines with an apb register file
// What this block does
// - uses only a clock line and data line
// - slave recognises 7-bit and 10-bit addresses
// - master can send 7-bit or 10-bit addresses
// - clock held low pauses, release resumes transfer
// - master detects collision and drops arbitration
// - full standard and fast mode functions
// - slave plus multi-master, 16-bit register view
// - control register fully readable, writable except bit 14
// - low six status bits are read-only
// - upper status bits are readable and writable
// - shift register hidden from software
// - receive buffer holds each received byte except on slave overrun, which keeps the old one
// - transmit register supplies bytes to send
// - own address register matched by slave
// - status flag shows 10-bit addressing
// - rate register reloads counter on restart
// - completed byte moves to buffer, pulses event
// - ack value picks ack or not-ack
// - ack start sends ack, self-clears
// - receive start receives byte, clears after eighth
// - stop start sends stop, self-clears
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module imsp_port (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe,
  input wire logic i_serial_data_pin,
  output logic o_serial_data_pin,
  output logic o_serial_data_pin_oe,
  output logic o_master_event,
  output logic o_slave_event
);
  logic [15:0] con_r, con_nxt, st_r, st_nxt, brg_r, brg_nxt, rv;
  logic [9:0] add_r, add_nxt;
  logic [7:0] trn_r, trn_nxt, rcv_r, rcv_nxt, m_sh_r, m_sh_nxt;
  logic [7:0] s_sh_r, s_sh_nxt;
  imsp_pkg::imsp_mst_t m_st_r, m_st_nxt;
  imsp_pkg::imsp_slv_t s_st_r, s_st_nxt;
  logic [1:0] m_ph_r, m_ph_nxt, pins_s;
  logic [2:0] m_cnt_r, m_cnt_nxt;
  logic [3:0] s_cnt_r, s_cnt_nxt;
  logic m_scl_r, m_scl_nxt, m_sda_r, m_sda_nxt, m_own_r, m_own_nxt;
  logic m_ackt_r, m_ackt_nxt, s_scl_r, s_scl_nxt, s_sda_r, s_sda_nxt;
  logic s_ackph_r, s_ackph_nxt, s_m10_r, s_m10_nxt, busy_r, busy_nxt;
  logic scl_d_r, sda_d_r, zero_r, scl_oe_nxt, sda_oe_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, m_ev_nxt, s_ev_nxt, mapped;
  logic scl_s, sda_s, tick, load, acc, wr, scl_rise, scl_fall;
  logic start_det, stop_det, s_ok, s_acc, rw;

  function automatic logic f_hit(input logic [7:0] a, input logic [7:0] o);
    f_hit = (a == o);
  endfunction

  imsp_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async({i_serial_clock_pin, i_serial_data_pin}),
    .o_sync(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // released clock still low means another party stretches: keep reloading
  assign load = (m_st_r == imsp_pkg::M_IDLE) | (~m_scl_r & ~scl_s);
  imsp_baud u_baud (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_load(load),
    .i_reload(brg_r),
    .o_tick(tick)
  );

  assign acc = i_psel & i_penable & o_pready;
  assign wr = acc & i_pwrite;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign s_ok = (m_st_r == imsp_pkg::M_IDLE) & ~m_own_r;
  assign rw = s_sh_r[0];

  always_comb
  begin
    con_nxt = con_r; st_nxt = st_r; add_nxt = add_r; brg_nxt = brg_r;
    trn_nxt = trn_r; rcv_nxt = rcv_r;
    m_st_nxt = m_st_r; m_ph_nxt = m_ph_r; m_cnt_nxt = m_cnt_r;
    m_sh_nxt = m_sh_r; m_scl_nxt = m_scl_r; m_sda_nxt = m_sda_r;
    m_own_nxt = m_own_r; m_ackt_nxt = m_ackt_r;
    s_st_nxt = s_st_r; s_cnt_nxt = s_cnt_r; s_sh_nxt = s_sh_r;
    s_scl_nxt = s_scl_r; s_sda_nxt = s_sda_r; s_ackph_nxt = s_ackph_r;
    s_m10_nxt = s_m10_r; busy_nxt = busy_r; s_acc = 1'b0;
    m_ev_nxt = 1'b0; s_ev_nxt = 1'b0;
    rv = imsp_pkg::REG_RST; mapped = 1'b1;
    if (f_hit(i_paddr, imsp_pkg::OFF_CON)) rv = con_r;
    else if (f_hit(i_paddr, imsp_pkg::OFF_STAT)) rv = st_r;
    else if (f_hit(i_paddr, imsp_pkg::OFF_ADD)) rv = {6'h00, add_r};
    else if (f_hit(i_paddr, imsp_pkg::OFF_TRN)) rv = {8'h00, trn_r};
    else if (f_hit(i_paddr, imsp_pkg::OFF_RCV)) rv = {8'h00, rcv_r};
    else if (f_hit(i_paddr, imsp_pkg::OFF_BRG)) rv = brg_r;
    else mapped = 1'b0;
    // zero-wait slave: answer prepared in the setup cycle
    pready_nxt = i_psel & ~i_penable;
    prdata_nxt = pready_nxt ? {16'h0000, rv} : 32'h0;
    pslverr_nxt = pready_nxt & ~mapped;
    if (wr)
    begin
      if (f_hit(i_paddr, imsp_pkg::OFF_CON))
        con_nxt = i_pwdata[15:0] & imsp_pkg::CON_WMASK;
      if (f_hit(i_paddr, imsp_pkg::OFF_STAT))
        st_nxt = {i_pwdata[15:6], st_r[5:0]};
      if (f_hit(i_paddr, imsp_pkg::OFF_ADD))
        add_nxt = i_pwdata[9:0];
      if (f_hit(i_paddr, imsp_pkg::OFF_BRG))
        brg_nxt = i_pwdata[15:0];
      if (f_hit(i_paddr, imsp_pkg::OFF_TRN))
      begin
        // a byte still waiting is never overwritten
        if (st_r[imsp_pkg::ST_TBF])
          st_nxt[imsp_pkg::ST_WCOL] = 1'b1;
        else
        begin
          trn_nxt = i_pwdata[7:0];
          st_nxt[imsp_pkg::ST_TBF] = 1'b1;
        end
      end
    end
    if (acc & ~i_pwrite & f_hit(i_paddr, imsp_pkg::OFF_RCV))
      st_nxt[imsp_pkg::ST_RBF] = 1'b0;

    // master engine; hardware updates follow software ones so hardware sets and clears win
    if (tick)
      m_ph_nxt = m_ph_r + 2'h1;
    unique case (m_st_r)
      imsp_pkg::M_IDLE:
      begin
        m_ph_nxt = 2'h0;
        m_cnt_nxt = 3'h0;
        if (con_r[imsp_pkg::CON_STARTS])
        begin
          if (busy_r | ~scl_s | ~sda_s)
          begin
            st_nxt[imsp_pkg::ST_BCL] = 1'b1;
            con_nxt[imsp_pkg::CON_STARTS] = 1'b0;
          end
          else
            m_st_nxt = imsp_pkg::M_START;
        end
        else if (m_own_r & con_r[imsp_pkg::CON_RSTS])
          m_st_nxt = imsp_pkg::M_REST;
        else if (m_own_r & con_r[imsp_pkg::CON_STOPS])
          m_st_nxt = imsp_pkg::M_STOP;
        else if (m_own_r & con_r[imsp_pkg::CON_RXS])
          m_st_nxt = imsp_pkg::M_RX;
        else if (m_own_r & con_r[imsp_pkg::CON_ACKS])
        begin
          m_st_nxt = imsp_pkg::M_ACK;
          m_ackt_nxt = 1'b1;
        end
        else if (m_own_r & st_r[imsp_pkg::ST_TBF])
        begin
          // address bytes, 7-bit or both 10-bit ones, go out like data
          m_st_nxt = imsp_pkg::M_TX;
          m_sh_nxt = trn_r;
          st_nxt[imsp_pkg::ST_TBF] = 1'b0;
          st_nxt[imsp_pkg::ST_TRSTAT] = 1'b1;
        end
      end
      imsp_pkg::M_START:
        if (tick)
        begin
          if (m_ph_r == 2'h0)
            m_sda_nxt = 1'b1;
          else
          begin
            m_scl_nxt = 1'b1;
            m_own_nxt = 1'b1;
            con_nxt[imsp_pkg::CON_STARTS] = 1'b0;
            m_st_nxt = imsp_pkg::M_IDLE;
            m_ev_nxt = 1'b1;
          end
        end
      imsp_pkg::M_REST:
        if (tick)
        begin
          unique case (m_ph_r)
            2'h0: m_sda_nxt = 1'b0;
            2'h1: m_scl_nxt = 1'b0;
            2'h2: m_sda_nxt = 1'b1;
            2'h3:
            begin
              m_scl_nxt = 1'b1;
              con_nxt[imsp_pkg::CON_RSTS] = 1'b0;
              m_st_nxt = imsp_pkg::M_IDLE;
              m_ev_nxt = 1'b1;
            end
          endcase
        end
      imsp_pkg::M_STOP:
        if (tick)
        begin
          if (m_ph_r == 2'h0)
            m_sda_nxt = 1'b1;
          else if (m_ph_r == 2'h1)
            m_scl_nxt = 1'b0;
          else
          begin
            m_sda_nxt = 1'b0;
            m_own_nxt = 1'b0;
            con_nxt[imsp_pkg::CON_STOPS] = 1'b0;
            m_st_nxt = imsp_pkg::M_IDLE;
            m_ev_nxt = 1'b1;
          end
        end
      imsp_pkg::M_TX, imsp_pkg::M_RX, imsp_pkg::M_ACK:
        if (tick)
        begin
          if (m_ph_r == 2'h0)
          begin
            if (m_st_r == imsp_pkg::M_TX)
              m_sda_nxt = ~m_sh_r[7];
            else if (m_st_r == imsp_pkg::M_ACK)
              m_sda_nxt = m_ackt_r & ~con_r[imsp_pkg::CON_ACKV];
            else
              m_sda_nxt = 1'b0;
          end
          else if (m_ph_r == 2'h1)
            m_scl_nxt = 1'b0;
          else
          begin
            m_ph_nxt = 2'h0;
            m_scl_nxt = 1'b1;
            m_cnt_nxt = m_cnt_r + 3'h1;
            m_sh_nxt = {m_sh_r[6:0], sda_s};
            if (m_st_r == imsp_pkg::M_TX & ~m_sda_r & ~sda_s)
            begin
              // lost arbitration: let go of both lines at once
              m_scl_nxt = 1'b0;
              m_sda_nxt = 1'b0;
              m_own_nxt = 1'b0;
              st_nxt[imsp_pkg::ST_BCL] = 1'b1;
              st_nxt[imsp_pkg::ST_TRSTAT] = 1'b0;
              m_st_nxt = imsp_pkg::M_IDLE;
              m_ev_nxt = 1'b1;
            end
            else if (m_st_r == imsp_pkg::M_TX & m_cnt_r == imsp_pkg::BIT_LAST)
            begin
              m_st_nxt = imsp_pkg::M_ACK;
              m_ackt_nxt = 1'b0;
            end
            else if (m_st_r == imsp_pkg::M_RX & m_cnt_r == imsp_pkg::BIT_LAST)
            begin
              rcv_nxt = {m_sh_r[6:0], sda_s};
              st_nxt[imsp_pkg::ST_OV] = st_r[imsp_pkg::ST_RBF];
              st_nxt[imsp_pkg::ST_RBF] = 1'b1;
              con_nxt[imsp_pkg::CON_RXS] = 1'b0;
              m_st_nxt = imsp_pkg::M_IDLE;
              m_ev_nxt = 1'b1;
            end
            else if (m_st_r == imsp_pkg::M_ACK)
            begin
              if (m_ackt_r)
                con_nxt[imsp_pkg::CON_ACKS] = 1'b0;
              else
              begin
                st_nxt[imsp_pkg::ST_ACKSTAT] = sda_s;
                st_nxt[imsp_pkg::ST_TRSTAT] = 1'b0;
              end
              m_st_nxt = imsp_pkg::M_IDLE;
              m_ev_nxt = 1'b1;
            end
          end
        end
    endcase

    // bus watch and slave engine
    if (start_det)
    begin
      busy_nxt = 1'b1;
      st_nxt[imsp_pkg::ST_START] = 1'b1;
      st_nxt[imsp_pkg::ST_STOP] = 1'b0;
      if (s_ok)
      begin
        s_st_nxt = imsp_pkg::S_ADDR;
        s_cnt_nxt = 4'h0;
        s_sda_nxt = 1'b0;
        s_ackph_nxt = 1'b0;
      end
    end
    else if (stop_det)
    begin
      busy_nxt = 1'b0;
      st_nxt[imsp_pkg::ST_STOP] = 1'b1;
      st_nxt[imsp_pkg::ST_START] = 1'b0;
      st_nxt[imsp_pkg::ST_TEN_BIT_ADDRESS_FLAG] = 1'b0;
      s_st_nxt = imsp_pkg::S_IDLE;
      s_scl_nxt = 1'b0;
      s_sda_nxt = 1'b0;
      s_m10_nxt = 1'b0;
    end
    else if (s_ok & s_st_r != imsp_pkg::S_IDLE)
    begin
      if (s_scl_r)
      begin
        if (con_r[imsp_pkg::CON_REL] &
            (s_st_r != imsp_pkg::S_TX | st_r[imsp_pkg::ST_TBF]))
        begin
          s_scl_nxt = 1'b0;
          if (s_st_r == imsp_pkg::S_TX)
          begin
            s_sh_nxt = trn_r;
            s_sda_nxt = ~trn_r[7];
            s_cnt_nxt = 4'h0;
            st_nxt[imsp_pkg::ST_TBF] = 1'b0;
          end
        end
      end
      else if (scl_rise)
      begin
        if (~s_ackph_r)
        begin
          s_cnt_nxt = s_cnt_r + 4'h1;
          s_sh_nxt = {s_sh_r[6:0], sda_s & (s_st_r != imsp_pkg::S_TX)};
        end
        else if (s_st_r == imsp_pkg::S_TX)
        begin
          st_nxt[imsp_pkg::ST_ACKSTAT] = sda_s;
          if (sda_s)
            s_st_nxt = imsp_pkg::S_IDLE;
        end
      end
      else if (scl_fall)
      begin
        if (s_ackph_r)
        begin
          s_ackph_nxt = 1'b0;
          s_sda_nxt = 1'b0;
          if (s_st_r == imsp_pkg::S_TX |
              (s_st_r == imsp_pkg::S_RX & con_r[imsp_pkg::CON_STRETCH_ENABLE]))
          begin
            // hold the clock until software frees it
            s_scl_nxt = 1'b1;
            con_nxt[imsp_pkg::CON_REL] = 1'b0;
          end
        end
        else if (s_st_r == imsp_pkg::S_TX)
        begin
          if (s_cnt_r == imsp_pkg::BYTE_BITS)
            s_ackph_nxt = 1'b1;
          s_sda_nxt = (s_cnt_r != imsp_pkg::BYTE_BITS) & ~s_sh_r[7];
        end
        else if (s_cnt_r == imsp_pkg::BYTE_BITS)
        begin
          s_st_nxt = imsp_pkg::S_IDLE;
          if (s_st_r == imsp_pkg::S_ADDR & con_r[imsp_pkg::CON_A10M])
          begin
            if (s_sh_r[7:3] == imsp_pkg::TEN_HDR &
                s_sh_r[2:1] == add_r[9:8] & (~rw | s_m10_r))
            begin
              s_acc = 1'b1;
              s_st_nxt = rw ? imsp_pkg::S_TX : imsp_pkg::S_ADDR2;
            end
          end
          else if (s_st_r == imsp_pkg::S_ADDR)
          begin
            if (s_sh_r[7:1] == add_r[6:0] | con_r[imsp_pkg::CON_IPMI] |
                (con_r[imsp_pkg::CON_GCEN] &
                 s_sh_r[7:1] == imsp_pkg::GCALL & ~rw))
            begin
              s_acc = 1'b1;
              s_st_nxt = rw ? imsp_pkg::S_TX : imsp_pkg::S_RX;
            end
          end
          else if (s_st_r == imsp_pkg::S_ADDR2)
          begin
            if (s_sh_r == add_r[7:0])
            begin
              s_acc = 1'b1;
              s_m10_nxt = 1'b1;
              st_nxt[imsp_pkg::ST_TEN_BIT_ADDRESS_FLAG] = 1'b1;
              s_st_nxt = imsp_pkg::S_RX;
            end
          end
          else
          begin
            // overrun: keep the old byte and answer not-ack
            s_st_nxt = imsp_pkg::S_RX;
            s_acc = ~st_r[imsp_pkg::ST_RBF];
            st_nxt[imsp_pkg::ST_OV] = st_r[imsp_pkg::ST_RBF];
            if (~st_r[imsp_pkg::ST_RBF])
              rcv_nxt = s_sh_r;
            st_nxt[imsp_pkg::ST_RBF] = 1'b1;
            st_nxt[imsp_pkg::ST_DATA] = 1'b1;
            s_ackph_nxt = 1'b1;
            s_cnt_nxt = 4'h0;
            s_ev_nxt = 1'b1;
          end
          if (s_acc)
          begin
            s_sda_nxt = 1'b1;
            s_ackph_nxt = 1'b1;
            s_cnt_nxt = 4'h0;
            s_ev_nxt = 1'b1;
            if (s_st_r != imsp_pkg::S_RX)
            begin
              st_nxt[imsp_pkg::ST_RW] = rw;
              st_nxt[imsp_pkg::ST_DATA] = 1'b0;
            end
          end
        end
      end
    end

    if (~con_r[imsp_pkg::CON_EN])
    begin
      m_st_nxt = imsp_pkg::M_IDLE;
      s_st_nxt = imsp_pkg::S_IDLE;
      {m_scl_nxt, m_sda_nxt, m_own_nxt, s_scl_nxt, s_sda_nxt} = 5'h00;
    end
    scl_oe_nxt = con_r[imsp_pkg::CON_EN] & (m_scl_nxt | s_scl_nxt);
    sda_oe_nxt = con_r[imsp_pkg::CON_EN] & (m_sda_nxt | s_sda_nxt);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      con_r <= imsp_pkg::CON_RST;
      {st_r, brg_r} <= {imsp_pkg::REG_RST, imsp_pkg::REG_RST};
      {add_r, trn_r, rcv_r, m_sh_r, s_sh_r} <= 42'h0;
      m_st_r <= imsp_pkg::M_IDLE;
      s_st_r <= imsp_pkg::S_IDLE;
      {m_ph_r, m_cnt_r, s_cnt_r} <= 9'h000;
      {m_scl_r, m_sda_r, m_own_r, m_ackt_r} <= 4'h0;
      {s_scl_r, s_sda_r, s_ackph_r, s_m10_r, busy_r} <= 5'h00;
      {scl_d_r, sda_d_r, zero_r} <= 3'h6;
      {o_prdata, o_pready, o_pslverr} <= 34'h0;
      {o_serial_clock_pin_oe, o_serial_data_pin_oe} <= 2'h0;
      {o_master_event, o_slave_event} <= 2'h0;
    end
    else
    begin
      {con_r, st_r, brg_r} <= {con_nxt, st_nxt, brg_nxt};
      {add_r, trn_r, rcv_r} <= {add_nxt, trn_nxt, rcv_nxt};
      {m_sh_r, s_sh_r} <= {m_sh_nxt, s_sh_nxt};
      m_st_r <= m_st_nxt;
      s_st_r <= s_st_nxt;
      {m_ph_r, m_cnt_r, s_cnt_r} <= {m_ph_nxt, m_cnt_nxt, s_cnt_nxt};
      {m_scl_r, m_sda_r, m_own_r} <= {m_scl_nxt, m_sda_nxt, m_own_nxt};
      m_ackt_r <= m_ackt_nxt;
      {s_scl_r, s_sda_r, s_ackph_r} <= {s_scl_nxt, s_sda_nxt, s_ackph_nxt};
      {s_m10_r, busy_r} <= {s_m10_nxt, busy_nxt};
      {scl_d_r, sda_d_r, zero_r} <= {scl_s, sda_s, 1'b0};
      {o_prdata, o_pready, o_pslverr} <= {prdata_nxt, pready_nxt, pslverr_nxt};
      o_serial_clock_pin_oe <= scl_oe_nxt;
      o_serial_data_pin_oe <= sda_oe_nxt;
      {o_master_event, o_slave_event} <= {m_ev_nxt, s_ev_nxt};
    end
  end
  // pins only ever pull low
  assign o_serial_clock_pin = zero_r;
  assign o_serial_data_pin = zero_r;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  ctl_rw_a: assert property (
    (wr && f_hit(i_paddr, imsp_pkg::OFF_CON))
    |=> con_r[11:5] == $past(i_pwdata[11:5]))
    else $error("control write not kept");
  stat_rw_a: assert property (
    (wr && f_hit(i_paddr, imsp_pkg::OFF_STAT))
    |=> st_r[imsp_pkg::ST_WCOL] == $past(i_pwdata[imsp_pkg::ST_WCOL]))
    else $error("status upper write not kept");
  rx_byte_a: assert property (
    (m_st_r == imsp_pkg::M_RX && tick && m_ph_r == 2'h2 &&
     m_cnt_r == imsp_pkg::BIT_LAST && con_r[imsp_pkg::CON_EN])
    |=> st_r[imsp_pkg::ST_RBF] && !con_r[imsp_pkg::CON_RXS]
        && rcv_r[0] == $past(sda_s) && o_master_event)
    else $error("received byte not buffered");
  bus_lost_a: assert property (
    (m_st_r == imsp_pkg::M_TX && tick && m_ph_r == 2'h2 && !m_sda_r &&
     !sda_s && con_r[imsp_pkg::CON_EN])
    |=> st_r[imsp_pkg::ST_BCL] && !m_own_r && m_st_r == imsp_pkg::M_IDLE)
    else $error("collision not handled");
  ack_value_a: assert property (
    (m_st_r == imsp_pkg::M_ACK && m_ackt_r && tick && m_ph_r == 2'h0 &&
     con_r[imsp_pkg::CON_EN])
    |=> m_sda_r == !$past(con_r[imsp_pkg::CON_ACKV]))
    else $error("wrong acknowledge level");
  ack_done_a: assert property (
    (m_st_r == imsp_pkg::M_ACK && m_ackt_r && tick && m_ph_r == 2'h2)
    |=> !con_r[imsp_pkg::CON_ACKS] && o_master_event)
    else $error("ack start not cleared");
  stop_done_a: assert property (
    (m_st_r == imsp_pkg::M_STOP && tick && m_ph_r == 2'h2)
    |=> !con_r[imsp_pkg::CON_STOPS] && !m_own_r && !m_sda_r)
    else $error("stop start not cleared");
  clk_free_a: assert property (
    (s_scl_r && con_r[imsp_pkg::CON_REL] && s_ok &&
     s_st_r == imsp_pkg::S_RX && !start_det)
    |=> !s_scl_r ##1 (!o_serial_clock_pin_oe || m_scl_r))
    else $error("clock release ignored");
  pin_drive_a: assert property (
    (m_scl_r || s_scl_r) |-> o_serial_clock_pin_oe && !o_serial_clock_pin)
    else $error("clock line not pulled low");
endmodule

// *** hw/imsp_pkg.sv ***
// constants and types shared by the two-wire bus port
package imsp_pkg;
  localparam logic [7:0] OFF_CON = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ADD = 8'h08;
  localparam logic [7:0] OFF_TRN = 8'h0c;
  localparam logic [7:0] OFF_RCV = 8'h10;
  localparam logic [7:0] OFF_BRG = 8'h14;
  localparam int CON_EN = 15;
  localparam int CON_REL = 12;
  localparam int CON_IPMI = 11;
  localparam int CON_A10M = 10;
  localparam int CON_GCEN = 7;
  localparam int CON_STRETCH_ENABLE = 6;
  localparam int CON_ACKV = 5;
  localparam int CON_ACKS = 4;
  localparam int CON_RXS = 3;
  localparam int CON_STOPS = 2;
  localparam int CON_RSTS = 1;
  localparam int CON_STARTS = 0;
  localparam logic [15:0] CON_RST = 16'h1000;
  localparam logic [15:0] CON_WMASK = 16'hbfff;
  localparam int ST_TBF = 0;
  localparam int ST_RBF = 1;
  localparam int ST_RW = 2;
  localparam int ST_START = 3;
  localparam int ST_STOP = 4;
  localparam int ST_DATA = 5;
  localparam int ST_OV = 6;
  localparam int ST_WCOL = 7;
  localparam int ST_TEN_BIT_ADDRESS_FLAG = 8;
  localparam int ST_BCL = 10;
  localparam int ST_TRSTAT = 14;
  localparam int ST_ACKSTAT = 15;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [6:0] GCALL = 7'h00;
  localparam logic [4:0] TEN_HDR = 5'h1e;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [6:0] {
    M_IDLE = 7'h01, M_START = 7'h02, M_REST = 7'h04, M_TX = 7'h08,
    M_RX = 7'h10, M_ACK = 7'h20, M_STOP = 7'h40
  } imsp_mst_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_ADDR = 5'h02, S_ADDR2 = 5'h04, S_RX = 5'h08,
    S_TX = 5'h10
  } imsp_slv_t;
endpackage

// *** hw/imsp_sync.sv ***
// two-stage synchroniser for the bus clock and data lines
`timescale 1ns/1ps
module imsp_sync (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [1:0] i_async,
  output logic [1:0] o_sync
);
  logic [1:0] meta_r;
  logic [1:0] meta_nxt;
  logic [1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  // idle bus reads high, so reset to that level
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      meta_r <= 2'h3;
      o_sync <= 2'h3;
    end
    else
    begin
      meta_r <= meta_nxt;
      o_sync <= sync_nxt;
    end
  end
endmodule

// *** hw/imsp_baud.sv ***
// serial clock rate counter with reload
`timescale 1ns/1ps
module imsp_baud (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [15:0] i_reload,
  output logic o_tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  always_comb
  begin
    o_tick = ~i_load & (cnt_r == 16'h0000);
    if (i_load | o_tick)
      cnt_nxt = i_reload;
    else
      cnt_nxt = cnt_r - 16'h0001;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      cnt_r <= imsp_pkg::REG_RST;
    else
      cnt_r <= cnt_nxt;
  end

  baud_reload_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_tick || i_load) |=> cnt_r == $past(i_reload))
    else $error("rate counter did not reload");
endmodule

// *** bench/imsp_bus_model.sv ***
// far-side bus device: pull-ups on both wires and a slave that acks bytes
`timescale 1ns/1ps
module imsp_bus_model (
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda,
  output logic [7:0] o_byte
);
  logic ack_r = 1'b0;
  logic p_scl = 1'b1;
  logic p_sda = 1'b1;
  int cnt = 15;
  // wired-and with pull-ups: a released wire reads high
  assign o_scl = ~i_scl_oe;
  assign o_sda = ~(i_sda_oe | ack_r);
  always @(o_scl or o_sda)
  begin
    if (p_scl && o_scl && p_sda && !o_sda)
      cnt = 0;
    else if (!p_scl && o_scl)
    begin
      // data sampled on the rising clock, msb first
      if (cnt < 8)
        o_byte = {o_byte[6:0], o_sda};
      cnt = (cnt < 8) ? cnt + 1 : 9;
    end
    else if (p_scl && !o_scl)
    begin
      // ack is pulled low through the whole ninth clock
      ack_r = (cnt == 8);
      if (cnt == 9)
        cnt = 0;
    end
    p_scl = o_scl;
    p_sda = o_sda;
  end
endmodule

// *** bench/imsp_port_tb.sv ***
// self-checking bench for the two-wire bus port
`timescale 1ns/1ps
module imsp_port_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic stop_start = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h00000000;
  logic [31:0] prd;
  logic prdy, perr, scl_o, scl_oe, sda_o, sda_oe, mev, sev, scl, sda;
  logic [7:0] seen;
  logic [15:0] rd;
  logic er;
  logic [7:0] bytes [2] = '{8'ha4, 8'h5b};
  int error_cnt = 0;
  int n_tests = 0;
  imsp_port DUT (.i_clk_sys(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(stop_start), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_serial_clock_pin(scl), .o_serial_clock_pin(scl_o),
    .o_serial_clock_pin_oe(scl_oe), .i_serial_data_pin(sda),
    .o_serial_data_pin(sda_o), .o_serial_data_pin_oe(sda_oe),
    .o_master_event(mev), .o_slave_event(sev));
  imsp_bus_model peer (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .o_scl(scl),
    .o_sda(sda), .o_byte(seen));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= {16'h0000, d};
    @(posedge clk);
    stop_start <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rd = prd[15:0];
    er = perr;
    psel <= 1'b0;
    stop_start <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(rd, e);
  endtask
  // bounded wait for the one-cycle master pulse
  task automatic wev();
    int n;
    n = 0;
    while (mev !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    chk(16'(n < 4000), 16'h0001);
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(imsp_pkg::OFF_CON, 16'h1000);
    rd_chk(imsp_pkg::OFF_STAT, 16'h0000);
    apb(1'b1, imsp_pkg::OFF_CON, 16'hbfe0);
    rd_chk(imsp_pkg::OFF_CON, 16'hbfe0);
    apb(1'b1, imsp_pkg::OFF_STAT, 16'h00ff);
    rd_chk(imsp_pkg::OFF_STAT, 16'h00c0);
    apb(1'b1, imsp_pkg::OFF_STAT, 16'h0000);
    rd_chk(imsp_pkg::OFF_STAT, 16'h0000);
    apb(1'b1, imsp_pkg::OFF_ADD, 16'hffff);
    rd_chk(imsp_pkg::OFF_ADD, 16'h03ff);
    apb(1'b1, imsp_pkg::OFF_BRG, 16'h0003);
    rd_chk(imsp_pkg::OFF_BRG, 16'h0003);
    rd_chk(8'h18, 16'h0000);
    chk({15'h0000, er}, 16'h0001);
    apb(1'b1, imsp_pkg::OFF_CON, 16'h9001);
    wev();
    rd_chk(imsp_pkg::OFF_CON, 16'h9000);
    foreach (bytes[i])
    begin
      apb(1'b1, imsp_pkg::OFF_TRN, {8'h00, bytes[i]});
      wev();
      chk({8'h00, seen}, {8'h00, bytes[i]});
      apb(1'b0, imsp_pkg::OFF_STAT, 16'h0000);
      chk(rd & 16'h8001, 16'h0000);
    end
    apb(1'b1, imsp_pkg::OFF_CON, 16'h9002);
    wev();
    rd_chk(imsp_pkg::OFF_CON, 16'h9000);
    // nobody drives data, so the pull-up makes every received bit a one
    apb(1'b1, imsp_pkg::OFF_CON, 16'h9008);
    wev();
    rd_chk(imsp_pkg::OFF_CON, 16'h9000);
    apb(1'b0, imsp_pkg::OFF_STAT, 16'h0000);
    chk(rd & 16'h0002, 16'h0002);
    rd_chk(imsp_pkg::OFF_RCV, 16'h00ff);
    apb(1'b1, imsp_pkg::OFF_CON, 16'h9030);
    wev();
    rd_chk(imsp_pkg::OFF_CON, 16'h9020);
    apb(1'b1, imsp_pkg::OFF_CON, 16'h9004);
    wev();
    rd_chk(imsp_pkg::OFF_CON, 16'h9000);
    chk({13'h0000, sev, scl_o, sda_o}, 16'h0000);
    tally_and_finish();
  end
endmodule
